//--- src/i2cmt_engine.sv
// I2C master transmit engine with a classic Wishbone register slave
//
// Overview of operation
// - Address byte is seven address bits then direction; high means read.
// - Acknowledge is SDA low in ninth bit; high there means no acknowledge.
// - While the interrupt flag is set, transfer waits; SCL is held low except after arbitration loss.
// - With assert_ack clear the engine never answers as a slave.
// - A start request issues START as soon as the bus is free.
// - After START the flag is set with status 0x08.
// - In 0x08 or 0x10 a flag clear sends the address byte, samples ack.
// - After the address phase the flag rises with 0x18, 0x20, 0x38, 0x40 or 0x48.
// - Slave-side codes after address phase only when slave mode exists.
// - Address-plus-write acked gives 0x18, not acked gives 0x20.
// - Data byte acked gives 0x28, not acked gives 0x30.
// - In transmit states, flag clear with no requests sends next byte.
// - Flag clear with start only issues a repeated START.
// - Flag clear with stop only sends STOP; hardware clears stop bit.
// - Flag clear with start and stop sends STOP then a new START.
// - In 0x10 an address-read byte is sent, then master receive takes over.
// - Arbitration loss with no start request releases the bus.
// - Arbitration loss with start request retries START when bus frees.
// - Status holds five code bits, stable while flag set, low bits zero.
// - Set port sets the EN, STA, STO and AA bits at ones; clear port clears EN, STA, SI and AA.
// - Writing one to the flag clear bit clears the interrupt flag.
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "i2cmt_consts.svh"

module i2cmt_engine
  import i2cmt_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  output logic MASTER_RX
);

  i2cmt_state_t st_q;
  i2cmt_state_t st_d;
  logic ack_q;
  logic [31:0] rdat_q;
  logic req;
  logic wr_stb;
  logic en_q;
  logic sta_q;
  logic sto_q;
  logic si_q;
  logic aa_q;
  logic [4:0] stat_q;
  logic [7:0] dat_q;
  logic [15:0] clock_high_count_q;
  logic [15:0] clock_low_count_q;
  logic scl_m;
  logic scl_s;
  logic sda_m;
  logic sda_s;
  logic sda_p;
  logic busy_q;
  logic [15:0] cnt_q;
  logic tick;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic addr_byte_q;
  logic rd_q;
  logic rs_q;
  logic si_set;
  logic [7:0] code_d;
  logic sto_done;
  logic arb_lost;
  logic xmit_ok;
  logic mrx_q;
  logic scl_oe_q;
  logic sda_oe_q;

  // Phases in which this engine pulls SCL low
  function automatic logic is_low(input i2cmt_state_t s);
    is_low = (s == ST_HOLD) || (s == ST_BLOW) || (s == ST_RS1) ||
             (s == ST_STOP1);
  endfunction : is_low

  // Phases whose high time waits for SCL really high
  function automatic logic is_high_wait(input i2cmt_state_t s);
    is_high_wait = (s == ST_BHIGH) || (s == ST_RS2) || (s == ST_STOP2);
  endfunction : is_high_wait

  // Latched five-bit status matches a full eight-bit code
  function automatic logic stat_is(input logic [4:0] s,
                                   input logic [7:0] c);
    stat_is = (s == c[7:3]);
  endfunction : stat_is

  // Wishbone request and write strobe at the acknowledging edge
  assign req = WB_CYC_I && WB_STB_I;
  assign wr_stb = req && WB_WE_I && ack_q;

  // Registered acknowledge, one wait state, dropped after one cycle
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      ack_q <= 1'b0;
    else
      ack_q <= req && !ack_q;
  end

  // Read data mux; unmapped addresses read zero
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      rdat_q <= 32'h0000_0000;
    else if (req && !ack_q)
    begin
      case (WB_ADR_I)
        `I2CMT_A_CONTROL_SET_PORT: rdat_q <= {25'h0, en_q, sta_q, sto_q, si_q, aa_q,
                                    2'h0};
        `I2CMT_A_STAT: rdat_q <= {24'h0, stat_q, 3'h0};
        `I2CMT_A_DAT: rdat_q <= {24'h0, dat_q};
        `I2CMT_A_CLOCK_HIGH_COUNT: rdat_q <= {16'h0, clock_high_count_q};
        `I2CMT_A_CLOCK_LOW_COUNT: rdat_q <= {16'h0, clock_low_count_q};
        default: rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  // Control bits: set port, clear port, hardware set wins over clear
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      en_q <= 1'b0;
      sta_q <= 1'b0;
      sto_q <= 1'b0;
      si_q <= 1'b0;
      aa_q <= 1'b0;
    end
    else
    begin
      if (wr_stb && WB_SEL_I[0] && WB_ADR_I == `I2CMT_A_CONTROL_SET_PORT)
      begin
        en_q <= en_q | WB_DAT_I[`I2CMT_B_EN];
        sta_q <= sta_q | WB_DAT_I[`I2CMT_B_STA];
        aa_q <= aa_q | WB_DAT_I[`I2CMT_B_AA];
      end
      else if (wr_stb && WB_SEL_I[0] && WB_ADR_I == `I2CMT_A_CONTROL_CLEAR_PORT)
      begin
        en_q <= en_q & ~WB_DAT_I[`I2CMT_B_EN];
        sta_q <= sta_q & ~WB_DAT_I[`I2CMT_B_STA];
        aa_q <= aa_q & ~WB_DAT_I[`I2CMT_B_AA];
      end
      // Stop request: software set wins over hardware clear
      if (wr_stb && WB_SEL_I[0] && WB_ADR_I == `I2CMT_A_CONTROL_SET_PORT &&
          WB_DAT_I[`I2CMT_B_STO])
        sto_q <= 1'b1;
      else if (sto_done || !en_q)
        sto_q <= 1'b0;
      // Interrupt flag: only hardware sets it
      if (si_set)
        si_q <= 1'b1;
      else if (wr_stb && WB_SEL_I[0] && WB_ADR_I == `I2CMT_A_CONTROL_CLEAR_PORT &&
               WB_DAT_I[`I2CMT_B_SI])
        si_q <= 1'b0;
    end
  end

  // Data and bit-rate registers
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      dat_q <= 8'h00;
      clock_high_count_q <= `I2CMT_SCL_RST;
      clock_low_count_q <= `I2CMT_SCL_RST;
    end
    else if (wr_stb)
    begin
      if (WB_ADR_I == `I2CMT_A_DAT && WB_SEL_I[0])
        dat_q <= WB_DAT_I[7:0];
      if (WB_ADR_I == `I2CMT_A_CLOCK_HIGH_COUNT && WB_SEL_I[0])
        clock_high_count_q[7:0] <= WB_DAT_I[7:0];
      if (WB_ADR_I == `I2CMT_A_CLOCK_HIGH_COUNT && WB_SEL_I[1])
        clock_high_count_q[15:8] <= WB_DAT_I[15:8];
      if (WB_ADR_I == `I2CMT_A_CLOCK_LOW_COUNT && WB_SEL_I[0])
        clock_low_count_q[7:0] <= WB_DAT_I[7:0];
      if (WB_ADR_I == `I2CMT_A_CLOCK_LOW_COUNT && WB_SEL_I[1])
        clock_low_count_q[15:8] <= WB_DAT_I[15:8];
    end
  end

  // Status code latched only when the flag is raised
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      stat_q <= 5'(`I2CMT_S_IDLE >> 3);
    else if (si_set)
      stat_q <= code_d[7:3];
  end

  // Two-flop synchronisers for the bus lines, plus SDA history
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end
    else
    begin
      scl_m <= SCL_I;
      scl_s <= scl_m;
      sda_m <= SDA_I;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  // Bus busy between a seen START and a seen STOP
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      busy_q <= 1'b0;
    else if (scl_s && sda_p && !sda_s)
      busy_q <= 1'b1;
    else if (scl_s && !sda_p && sda_s)
      busy_q <= 1'b0;
  end

  // Phase timer: reload on phase change, pause while SCL stretched low
  assign tick = (cnt_q == `I2CMT_CNT_ZERO);
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      cnt_q <= `I2CMT_SCL_RST;
    else if (st_d != st_q)
      cnt_q <= is_low(st_d) ? clock_low_count_q : clock_high_count_q;
    else if (!tick && (!is_high_wait(st_q) || scl_s))
      cnt_q <= cnt_q - 16'h0001;
  end

  // Arbitration lost: released SDA seen low while SCL high
  assign arb_lost = (st_q == ST_BHIGH) && (bit_q != `I2CMT_ACK_BIT) &&
                    sh_q[7] && scl_s && !sda_s;
  assign xmit_ok = stat_is(stat_q, `I2CMT_S_START) ||
                   stat_is(stat_q, `I2CMT_S_RSTART) ||
                   stat_is(stat_q, `I2CMT_S_AW_ACK) ||
                   stat_is(stat_q, `I2CMT_S_AW_NACK) ||
                   stat_is(stat_q, `I2CMT_S_D_ACK) ||
                   stat_is(stat_q, `I2CMT_S_D_NACK);
  assign sto_done = (st_q == ST_STOP3) && tick;

  // Engine sequencing and status code selection
  always_comb
  begin
    st_d = st_q;
    si_set = 1'b0;
    code_d = `I2CMT_S_IDLE;
    case (st_q)
      ST_IDLE:
        if (en_q && sta_q && !si_q && !busy_q)
          st_d = ST_START;
      ST_START:
        if (tick)
        begin
          st_d = ST_HOLD;
          si_set = 1'b1;
          code_d = rs_q ? `I2CMT_S_RSTART : `I2CMT_S_START;
        end
      ST_HOLD:
        if (!si_q)
        begin
          if (sto_q)
            st_d = ST_STOP1;
          else if (sta_q)
            st_d = ST_RS1;
          else if (xmit_ok)
            st_d = ST_BLOW;
        end
      ST_BLOW:
        if (tick)
          st_d = ST_BHIGH;
      ST_BHIGH:
        if (arb_lost)
        begin
          st_d = ST_LOST;
          si_set = 1'b1;
          code_d = `I2CMT_S_ARB;
        end
        else if (tick && bit_q == `I2CMT_ACK_BIT)
        begin
          st_d = ST_HOLD;
          si_set = 1'b1;
          if (!addr_byte_q)
            code_d = sda_s ? `I2CMT_S_D_NACK : `I2CMT_S_D_ACK;
          else if (rd_q)
            code_d = sda_s ? `I2CMT_S_AR_NACK : `I2CMT_S_AR_ACK;
          else
            code_d = sda_s ? `I2CMT_S_AW_NACK : `I2CMT_S_AW_ACK;
        end
        else if (tick)
          st_d = ST_BLOW;
      ST_RS1:
        if (tick)
          st_d = ST_RS2;
      ST_RS2:
        if (tick)
          st_d = ST_START;
      ST_STOP1:
        if (tick)
          st_d = ST_STOP2;
      ST_STOP2:
        if (tick)
          st_d = ST_STOP3;
      ST_STOP3:
        if (tick)
          st_d = ST_IDLE;
      ST_LOST:
        if (!si_q)
          st_d = ST_IDLE;
      default:
        st_d = ST_IDLE;
    endcase
    if (!en_q)
      st_d = ST_IDLE;
  end

  // State register
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      st_q <= ST_IDLE;
    else
      st_q <= st_d;
  end

  // Shift register, bit count, byte kind and repeated-start marker
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      addr_byte_q <= 1'b0;
      rd_q <= 1'b0;
      rs_q <= 1'b0;
    end
    else
    begin
      if (st_q == ST_HOLD && st_d == ST_BLOW)
      begin
        sh_q <= dat_q;
        bit_q <= 4'h0;
        addr_byte_q <= stat_is(stat_q, `I2CMT_S_START) ||
                       stat_is(stat_q, `I2CMT_S_RSTART);
        rd_q <= dat_q[0];
      end
      else if (st_q == ST_BHIGH && st_d == ST_BLOW)
      begin
        sh_q <= {sh_q[6:0], 1'b0};
        bit_q <= bit_q + 4'h1;
      end
      if (st_d == ST_RS2)
        rs_q <= 1'b1;
      else if (st_d == ST_IDLE)
        rs_q <= 1'b0;
    end
  end

  // Handoff level to master receive after an address-read byte
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      mrx_q <= 1'b0;
    else if (si_set && (code_d == `I2CMT_S_AR_ACK ||
                        code_d == `I2CMT_S_AR_NACK))
      mrx_q <= 1'b1;
    else if (st_d != ST_HOLD)
      mrx_q <= 1'b0;
  end

  // Open-drain drivers; assert_ack never enables a slave answer here
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      scl_oe_q <= is_low(st_q);
      case (st_q)
        ST_START, ST_STOP1, ST_STOP2: sda_oe_q <= 1'b1;
        // SDA moves only once SCL is already pulled low
        ST_BLOW:
          if (scl_oe_q)
            sda_oe_q <= (bit_q != `I2CMT_ACK_BIT) && !sh_q[7];
        ST_HOLD, ST_BHIGH: sda_oe_q <= sda_oe_q;
        default: sda_oe_q <= 1'b0;
      endcase
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;
  assign SCL_OE = scl_oe_q;
  assign SDA_OE = sda_oe_q;
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign MASTER_RX = mrx_q;

  // Checks on the engine
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  property p_hold_stall;
    (st_q == ST_HOLD && si_q) ##1 si_q |-> scl_oe_q && st_q == ST_HOLD;
  endproperty
  a_hold_stall: assert property (p_hold_stall)
    else $error("SCL not held while flag set");

  property p_start_code;
    (st_q == ST_START && tick && !rs_q && en_q) |=>
      si_q && stat_q == 5'h01;
  endproperty
  a_start_code: assert property (p_start_code)
    else $error("START did not report 0x08");

  property p_stat_stable;
    si_q ##1 si_q |-> $stable(stat_q);
  endproperty
  a_stat_stable: assert property (p_stat_stable)
    else $error("Status changed while flag set");

  property p_start_free;
    st_q == ST_IDLE ##1 st_q == ST_START |-> !$past(busy_q) && $past(sta_q);
  endproperty
  a_start_free: assert property (p_start_free)
    else $error("START issued on busy bus");

  property p_sto_clear;
    (sto_done && !(wr_stb && WB_ADR_I == `I2CMT_A_CONTROL_SET_PORT)) |=> !sto_q;
  endproperty
  a_sto_clear: assert property (p_sto_clear)
    else $error("Stop request not cleared after STOP");

  property p_set_port;
    (wr_stb && WB_SEL_I[0] && WB_ADR_I == `I2CMT_A_CONTROL_SET_PORT &&
     WB_DAT_I[`I2CMT_B_STA]) |=> sta_q;
  endproperty
  a_set_port: assert property (p_set_port)
    else $error("Set port did not set start request");

  property p_flag_clear;
    (wr_stb && WB_SEL_I[0] && WB_ADR_I == `I2CMT_A_CONTROL_CLEAR_PORT &&
     WB_DAT_I[`I2CMT_B_SI] && !si_set) |=> !si_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("Flag clear bit did not clear flag");

  property p_ack_release;
    st_q == ST_BHIGH && bit_q == `I2CMT_ACK_BIT |-> !sda_oe_q;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("SDA driven during acknowledge bit");

  property p_aw_code;
    (si_set && st_q == ST_BHIGH && addr_byte_q && !rd_q && !arb_lost) |=>
      stat_q == ($past(sda_s) ? 5'h04 : 5'h03);
  endproperty
  a_aw_code: assert property (p_aw_code)
    else $error("Wrong address-write status");

  property p_lost_release;
    st_q == ST_LOST ##1 st_q == ST_LOST |-> !sda_oe_q && !scl_oe_q;
  endproperty
  a_lost_release: assert property (p_lost_release)
    else $error("Bus not released after arbitration loss");

  c_start: cover property (st_q == ST_START ##1 st_q == ST_HOLD);
  c_data_ack: cover property (si_set && code_d == `I2CMT_S_D_ACK);
  c_stop: cover property (sto_done);
  c_lost: cover property (st_q == ST_LOST);

endmodule : i2cmt_engine
`default_nettype wire

//--- src/i2cmt_consts.svh
// Register map, control fields, status codes and reset values
`ifndef I2CMT_CONSTS_SVH
`define I2CMT_CONSTS_SVH
`define I2CMT_A_CONTROL_SET_PORT 8'h00
`define I2CMT_A_STAT 8'h04
`define I2CMT_A_DAT 8'h08
`define I2CMT_A_CLOCK_HIGH_COUNT 8'h10
`define I2CMT_A_CLOCK_LOW_COUNT 8'h14
`define I2CMT_A_CONTROL_CLEAR_PORT 8'h18
`define I2CMT_B_EN 6
`define I2CMT_B_STA 5
`define I2CMT_B_STO 4
`define I2CMT_B_SI 3
`define I2CMT_B_AA 2
`define I2CMT_S_START 8'h08
`define I2CMT_S_RSTART 8'h10
`define I2CMT_S_AW_ACK 8'h18
`define I2CMT_S_AW_NACK 8'h20
`define I2CMT_S_D_ACK 8'h28
`define I2CMT_S_D_NACK 8'h30
`define I2CMT_S_ARB 8'h38
`define I2CMT_S_AR_ACK 8'h40
`define I2CMT_S_AR_NACK 8'h48
`define I2CMT_S_IDLE 8'hf8
`define I2CMT_SCL_RST 16'h0004
`define I2CMT_ACK_BIT 4'h8
`define I2CMT_CNT_ZERO 16'h0000
`endif

//--- src/i2cmt_pkg.sv
// Types shared by the master transmit engine
`default_nettype none
package i2cmt_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_START = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_BLOW = 4'b0011,
    ST_BHIGH = 4'b0100,
    ST_RS1 = 4'b0101,
    ST_RS2 = 4'b0110,
    ST_STOP1 = 4'b0111,
    ST_STOP2 = 4'b1000,
    ST_STOP3 = 4'b1001,
    ST_LOST = 4'b1010
  } i2cmt_state_t;
endpackage : i2cmt_pkg
`default_nettype wire

//--- verif/i2cmt_slave_model.sv
// Slave receiver on the far side of the bus, plus a competing master
`timescale 1ns/100ps
`default_nettype none

module i2cmt_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  input wire logic arb_en,
  output logic sda_oe,
  output logic [7:0] last_byte,
  output logic [7:0] n_start,
  output logic [7:0] n_stop,
  output logic [7:0] n_byte
);
  logic [3:0] bitn;
  logic [7:0] sh;
  logic ack_drv;

  // Counters and drivers start clear
  initial
  begin
    bitn = 4'h0;
    sh = 8'h00;
    ack_drv = 1'b0;
    last_byte = 8'h00;
    n_start = 8'h00;
    n_stop = 8'h00;
    n_byte = 8'h00;
  end

  // Competing master holds data low while asked to
  assign sda_oe = ack_drv | arb_en;

  // START: data falls while the clock is high
  always @(negedge sda)
  begin
    if (scl === 1'b1)
    begin
      n_start = n_start + 8'h01;
      bitn = 4'h0;
    end
  end

  // STOP: data rises while the clock is high, only once a frame began
  always @(posedge sda)
  begin
    if (scl === 1'b1 && n_start != 8'h00)
      n_stop = n_stop + 8'h01;
  end

  // Bits shift in most significant first on the rising clock
  always @(posedge scl)
  begin
    if (bitn < 4'h8)
    begin
      sh = {sh[6:0], sda};
      bitn = bitn + 4'h1;
    end
    else
      bitn = 4'h9;
  end

  // Ninth bit: pull data low to acknowledge, leave it high to refuse
  always @(negedge scl)
  begin
    if (bitn == 4'h8)
    begin
      last_byte = sh;
      n_byte = n_byte + 8'h01;
      ack_drv = ack_en;
    end
    else if (bitn == 4'h9)
    begin
      ack_drv = 1'b0;
      bitn = 4'h0;
    end
  end
endmodule : i2cmt_slave_model
`default_nettype wire

//--- verif/test_i2c_master_transmit_engine.sv
// Self-checking bench for the master transmit engine
`timescale 1ns/100ps
`default_nettype none

module test_i2c_master_transmit_engine;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wen = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic ack_en = 1'b1;
  logic arb_en = 1'b0;
  logic [31:0] dat_o;
  logic [31:0] rdat;
  logic ack, scl_o, scl_oe, sda_o, sda_oe, master_rx;
  logic scl, sda, m_sda_oe;
  logic [7:0] last_byte, n_start, n_stop, n_byte;
  int errors = 0;
  int total_checks = 0;

  // System clock at 100 MHz
  always #5 clk = ~clk;

  // Open-drain lines with pull-ups
  assign scl = (scl_oe && !scl_o) ? 1'b0 : 1'b1;
  assign sda = ((sda_oe && !sda_o) || m_sda_oe) ? 1'b0 : 1'b1;

  i2cmt_engine dut (.CLK(clk), .SYS_RST(sys_rst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(wen), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
    .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .SCL_I(scl),
    .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .MASTER_RX(master_rx));

  i2cmt_slave_model far (.scl(scl), .sda(sda), .ack_en(ack_en),
    .arb_en(arb_en), .sda_oe(m_sda_oe), .last_byte(last_byte),
    .n_start(n_start), .n_stop(n_stop), .n_byte(n_byte));

  // Verdict and end of run
  task wrap_up;
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // Compare and count
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask : cmp

  // One classic Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= we;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // Register read with expected value
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp(rdat, e);
  endtask : rd

  // Poll the control register until the masked bits match
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      wb(1'b0, 8'h00, 32'h0);
      n++;
    end
    while ((rdat & m) !== v && n < 600);
    if (n == 600)
      errors++;
  endtask : poll

  // Load data, set and clear control bits, wait for the flag, check status
  task automatic go(input logic [7:0] b, input logic [7:0] s,
                    input logic [7:0] c, input logic [7:0] code);
    wb(1'b1, 8'h08, {24'h0, b});
    wb(1'b1, 8'h00, {24'h0, s});
    wb(1'b1, 8'h18, {24'h0, c});
    poll(32'h08, 32'h08);
    rd(8'h04, {24'h0, code});
  endtask : go

  // Watchdog well beyond the expected few thousand cycles
  initial
  begin
    repeat (50000) @(posedge clk);
    errors++;
    wrap_up;
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h04, 32'hf8);
    rd(8'h10, 32'h4);
    rd(8'h14, 32'h4);
    rd(8'h0c, 32'h0);
    wb(1'b1, 8'h14, 32'h5);
    wb(1'b1, 8'h10, 32'h4);
    rd(8'h14, 32'h5);
    wb(1'b1, 8'h00, 32'h44);
    wb(1'b1, 8'h18, 32'h04);
    rd(8'h00, 32'h40);
    go(8'h00, 8'h20, 8'h00, 8'h08);
    repeat (60) @(posedge clk);
    cmp(scl, 1'b0);
    cmp(n_byte, 8'h0);
    rd(8'h04, 32'h08);
    go(8'ha4, 8'h00, 8'h28, 8'h18);
    cmp(last_byte, 8'ha4);
    go(8'h3c, 8'h00, 8'h08, 8'h28);
    ack_en <= 1'b0;
    go(8'hc3, 8'h00, 8'h08, 8'h30);
    cmp(last_byte, 8'hc3);
    go(8'h00, 8'h20, 8'h08, 8'h10);
    go(8'ha4, 8'h00, 8'h28, 8'h20);
    ack_en <= 1'b1;
    go(8'h00, 8'h20, 8'h08, 8'h10);
    go(8'ha5, 8'h00, 8'h28, 8'h40);
    cmp(master_rx, 1'b1);
    cmp(n_start, 8'h3);
    go(8'h00, 8'h20, 8'h08, 8'h10);
    ack_en <= 1'b0;
    go(8'ha5, 8'h00, 8'h28, 8'h48);
    ack_en <= 1'b1;
    cmp(master_rx, 1'b1);
    wb(1'b1, 8'h00, 32'h10);
    wb(1'b1, 8'h18, 32'h08);
    poll(32'h10, 32'h0);
    repeat (20) @(posedge clk);
    rd(8'h00, 32'h40);
    cmp(n_stop, 8'h1);
    cmp(master_rx, 1'b0);
    go(8'h00, 8'h20, 8'h00, 8'h08);
    go(8'ha4, 8'h00, 8'h28, 8'h18);
    go(8'h00, 8'h30, 8'h08, 8'h08);
    rd(8'h00, 32'h68);
    cmp(n_stop, 8'h2);
    arb_en <= 1'b1;
    go(8'ha4, 8'h00, 8'h28, 8'h38);
    cmp({scl_oe, sda_oe}, 2'b00);
    wb(1'b1, 8'h00, 32'h20);
    wb(1'b1, 8'h18, 32'h08);
    repeat (100) @(posedge clk);
    cmp(n_start, 8'h6);
    arb_en <= 1'b0;
    poll(32'h08, 32'h08);
    rd(8'h04, 32'h08);
    cmp(n_start, 8'h7);
    wb(1'b1, 8'h18, 32'h20);
    wb(1'b1, 8'h00, 32'h10);
    wb(1'b1, 8'h18, 32'h08);
    poll(32'h10, 32'h0);
    repeat (20) @(posedge clk);
    cmp(n_stop, 8'h4);
    wrap_up;
  end
endmodule : test_i2c_master_transmit_engine
`default_nettype wire
